// ---- hdl/hss_pkg.sv ----
// package for the hdlc status block: register map, field positions, codes.
// assumes a 32-bit classic wishbone bus with byte addresses.
package hss_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // status port index as printed; byte address is four times the index
  localparam logic [11:0] HSS_STAT_E_IDX  = 12'h0cb;
  localparam logic [11:0] HSS_STAT_F_IDX  = 12'h0d3;
  localparam logic [11:0] HSS_RXDATA_ADR  = 12'h400;
  localparam logic [11:0] HSS_TXDATA_ADR  = 12'h404;
  localparam logic [11:0] HSS_INTSTAT_ADR = 12'h408;
  localparam logic [11:0] HSS_INTMASK_ADR = 12'h40c;

  // ****************************************************************
  // status field positions
  // ****************************************************************
  localparam int HSS_B_RXFULL  = 7;
  localparam int HSS_B_FRM_HI  = 6;
  localparam int HSS_B_OVR     = 5;
  localparam int HSS_B_FRM_LO  = 4;
  localparam int HSS_B_TXFULL  = 3;
  localparam int HSS_B_CAUSE_H = 2;
  localparam int HSS_B_CAUSE_L = 1;
  localparam int HSS_B_SHORT   = 0;
  localparam int HSS_B_TXLAST  = 8;  // last-in-frame mark in tx data write

  // ****************************************************************
  // codes and reset values
  // ****************************************************************
  localparam logic [1:0] HSS_FRM_DATA  = 2'h0;
  localparam logic [1:0] HSS_FRM_ABORT = 2'h1;
  localparam logic [1:0] HSS_FRM_CRCOK = 2'h2;
  localparam logic [1:0] HSS_FRM_CRCER = 2'h3;
  localparam logic [1:0] HSS_CAUSE_EMPTY = 2'h0;
  localparam logic [1:0] HSS_CAUSE_CRC   = 2'h1;
  localparam logic [1:0] HSS_CAUSE_ABORT = 2'h2;
  localparam logic [1:0] HSS_CAUSE_FLAG  = 2'h3;
  localparam logic [1:0] HSS_FLAGS_ONE = 2'h1;
  localparam logic [1:0] HSS_FLAGS_TWO = 2'h2;
  localparam logic [2:0] HSS_INT_RST   = 3'h0;
  localparam int HSS_I_RX  = 0;  // sticky: byte received
  localparam int HSS_I_TX  = 1;  // sticky: transmit interrupt raised
  localparam int HSS_I_OVR = 2;  // sticky: receive overrun

endpackage

// ---- hdl/hss_status.sv ----
// hdlc serial port status register with receive/transmit holding buffers.
// assumes framer logic on the same clock gives one-cycle event pulses,
// and a classic wishbone master on the register side.
// Functional notes
// - bit 7 set while rx byte buffered; rx interrupt while it is set
// - frame field bits 6,4 read 00 for ordinary data byte
// - frame field reads 01 when byte was followed by abort
// - frame field 10 for last byte good crc, 11 for crc error
// - bit 5 set on rx overrun, cleared by reading rx buffer
// - bit 3 high while tx buffer holds an untaken byte
// - tx interrupt when transmitter takes byte, unless marked last in frame
// - tx interrupt cleared by tx buffer write or any status write
// - cause bits 2:1 read 00 for tx buffer empty interrupt
// - tx interrupt with cause 01 when crc sending finishes
// - data answering crc interrupt gets exactly one flag, no interrupt
// - tx interrupt with cause 10 when abort sending finishes
// - cause 11 after closing flag; answering data gets two or more flags
// - bit 0 set when buffered rx byte has fewer than 8 bits
//
// Our own choice: the Wishbone register port.
module hss_status
  import hss_pkg::*;
#(
  parameter logic [11:0] STAT_IDX = HSS_STAT_E_IDX
)(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // receiver side
  input  wire logic        rx_load_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [1:0]  rx_frame_i,
  input  wire logic        rx_short_i,
  // transmitter side
  input  wire logic        tx_take_i,
  input  wire logic        tx_crc_done_i,
  input  wire logic        tx_abort_done_i,
  input  wire logic        tx_flag_done_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_last_o,
  output logic             tx_valid_o,
  output logic      [1:0]  tx_min_flags_o,
  // interrupts
  output logic             rx_irq_o,
  output logic             tx_irq_o,
  output logic             irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic        ack_r;
  logic [31:0] dat_r;
  logic        rx_full_r;
  logic [7:0]  rx_data_r;
  logic [1:0]  rx_frame_r;
  logic        rx_short_r;
  logic        rx_ovr_r;
  logic        tx_full_r;
  logic [7:0]  tx_data_r;
  logic        tx_last_r;
  logic        tx_irq_r;
  logic [1:0]  tx_cause_r;
  logic [1:0]  tx_flags_r;
  logic        flag_quiet_r;
  logic [2:0]  int_sts_r;
  logic [2:0]  int_msk_r;
  logic        irq_r;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit_stat;
  logic        stat_wr;
  logic        rx_rd;
  logic        tx_wr;
  logic        ists_wr;
  logic        imsk_wr;
  logic [7:0]  stat;
  logic [31:0] rd_mux;
  logic        tx_evt;
  logic [2:0]  int_evt;
  logic [11:0] stat_adr;

  // the access is acted on in the edge that raises ack, once only
  assign stat_adr = {STAT_IDX[9:0], 2'h0};
  assign acc      = ce_i & cyc_i & stb_i & ~ack_r;
  assign wr       = acc & we_i & sel_i[0];
  assign rd       = acc & ~we_i;
  assign hit_stat = (adr_i == stat_adr);
  assign stat_wr  = wr & hit_stat;
  assign rx_rd    = rd & (adr_i == HSS_RXDATA_ADR);
  assign tx_wr    = wr & (adr_i == HSS_TXDATA_ADR);
  assign ists_wr  = wr & (adr_i == HSS_INTSTAT_ADR);
  assign imsk_wr  = wr & (adr_i == HSS_INTMASK_ADR);

  // status byte assembly
  always_comb
  begin
    stat                = 8'h00;
    stat[HSS_B_RXFULL]  = rx_full_r;
    stat[HSS_B_FRM_HI]  = rx_frame_r[1];
    stat[HSS_B_FRM_LO]  = rx_frame_r[0];
    stat[HSS_B_OVR]     = rx_ovr_r;
    stat[HSS_B_TXFULL]  = tx_full_r;
    stat[HSS_B_CAUSE_H] = tx_cause_r[1];
    stat[HSS_B_CAUSE_L] = tx_cause_r[0];
    stat[HSS_B_SHORT]   = rx_short_r;
  end

  // read data select; unmapped addresses read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_stat)
    begin
      rd_mux[7:0] = stat;
    end
    else if (adr_i == HSS_RXDATA_ADR)
    begin
      rd_mux[7:0] = rx_data_r;
    end
    else if (adr_i == HSS_TXDATA_ADR)
    begin
      rd_mux[8:0] = {tx_last_r, tx_data_r};
    end
    else if (adr_i == HSS_INTSTAT_ADR)
    begin
      rd_mux[2:0] = int_sts_r;
    end
    else if (adr_i == HSS_INTMASK_ADR)
    begin
      rd_mux[2:0] = int_msk_r;
    end
  end

  // ****************************************************************
  // wishbone answer
  // ****************************************************************
  // one wait state: ack follows the request by one edge, drops after one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      if (acc)
      begin
        dat_r <= we_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ****************************************************************
  // receive holding buffer
  // ****************************************************************
  // a new byte overwrites the held one; the overrun bit records the loss
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_full_r  <= 1'b0;
      rx_data_r  <= 8'h00;
      rx_frame_r <= HSS_FRM_DATA;
      rx_short_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rx_load_i)
      begin
        rx_full_r  <= 1'b1;            // load wins over a same-cycle read
        rx_data_r  <= rx_data_i;
        rx_frame_r <= rx_frame_i;
        rx_short_r <= rx_short_i;
      end
      else if (rx_rd)
      begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // overrun flag: a load into a full, unread buffer sets it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_ovr_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rx_load_i & rx_full_r & ~rx_rd)
      begin
        rx_ovr_r <= 1'b1;
      end
      else if (rx_rd)
      begin
        rx_ovr_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // transmit holding buffer
  // ****************************************************************
  // writes while full replace the byte; software should watch bit 3
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_full_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_last_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (tx_wr)
      begin
        tx_full_r <= 1'b1;
        tx_data_r <= dat_i[7:0];
        tx_last_r <= dat_i[HSS_B_TXLAST];
      end
      else if (tx_take_i)
      begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // transmit interrupt and cause
  // ****************************************************************
  // any transmit event; an event in the clearing cycle still wins
  assign tx_evt = (tx_take_i & tx_full_r & ~tx_last_r)
                | tx_crc_done_i
                | tx_abort_done_i
                | (tx_flag_done_i & ~flag_quiet_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_irq_r   <= 1'b0;
      tx_cause_r <= HSS_CAUSE_EMPTY;
    end
    else if (ce_i)
    begin
      if (tx_evt)
      begin
        tx_irq_r <= 1'b1;
        if (tx_crc_done_i)
        begin
          tx_cause_r <= HSS_CAUSE_CRC;
        end
        else if (tx_abort_done_i)
        begin
          tx_cause_r <= HSS_CAUSE_ABORT;
        end
        else if (tx_flag_done_i & ~flag_quiet_r)
        begin
          tx_cause_r <= HSS_CAUSE_FLAG;
        end
        else
        begin
          tx_cause_r <= HSS_CAUSE_EMPTY;
        end
      end
      else if (tx_wr | stat_wr)
      begin
        tx_irq_r <= 1'b0;                  // written value ignored
      end
    end
  end

  // flag spacing told to the transmitter for the next frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_flags_r   <= HSS_FLAGS_TWO;
      flag_quiet_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (tx_wr & tx_irq_r & (tx_cause_r == HSS_CAUSE_CRC))
      begin
        tx_flags_r   <= HSS_FLAGS_ONE;
        flag_quiet_r <= 1'b1;              // separating flag is silent
      end
      else if (tx_wr)
      begin
        tx_flags_r   <= HSS_FLAGS_TWO;
        flag_quiet_r <= 1'b0;
      end
      else if (tx_flag_done_i)
      begin
        flag_quiet_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // sticky interrupt status and mask
  // ****************************************************************
  assign int_evt = {rx_load_i & rx_full_r & ~rx_rd, tx_evt, rx_load_i};

  // per-bit write-one-to-clear; a same-cycle event keeps the bit set
  for (genvar i = 0; i < 3; i++)
  begin : g_int
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        int_sts_r[i] <= HSS_INT_RST[i];
      end
      else if (ce_i)
      begin
        if (int_evt[i])
        begin
          int_sts_r[i] <= 1'b1;
        end
        else if (ists_wr & dat_i[i])
        begin
          int_sts_r[i] <= 1'b0;
        end
      end
    end
  end

  // mask and registered interrupt outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_msk_r <= HSS_INT_RST;
      irq_r     <= 1'b0;
    end
    else if (ce_i)
    begin
      if (imsk_wr)
      begin
        int_msk_r <= dat_i[2:0];
      end
      irq_r <= |(int_sts_r & int_msk_r);
    end
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign dat_o          = dat_r;
  assign ack_o          = ack_r;
  assign tx_data_o      = tx_data_r;
  assign tx_last_o      = tx_last_r;
  assign tx_valid_o     = tx_full_r;
  assign tx_min_flags_o = tx_flags_r;
  assign rx_irq_o       = rx_full_r;       // level while byte waits
  assign tx_irq_o       = tx_irq_r;
  assign irq_o          = irq_r;

endmodule

// ---- tb/hss_status_asserts.sv ----
// checker for the hdlc status block, bound to hss_status.
// assumes one clock, synchronous active-high reset, bus answer in 1 cycle.
module hss_status_asserts
  import hss_pkg::*;
#(
  parameter logic [11:0] STAT_IDX = HSS_STAT_E_IDX
)(
  // clock and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic        ack_o,
  // framer side and flags
  input wire logic        rx_load_i,
  input wire logic        tx_take_i,
  input wire logic        tx_crc_done_i,
  input wire logic        tx_abort_done_i,
  input wire logic        tx_flag_done_i,
  input wire logic        tx_last_o,
  input wire logic        tx_valid_o,
  input wire logic        rx_irq_o,
  input wire logic        tx_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // taken requests
  // ****
  logic req, wr_tx, wr_st, tx_ev;
  assign req   = cyc_i && stb_i && !ack_o && ce_i;
  assign wr_tx = req && we_i && sel_i[0] && adr_i == HSS_TXDATA_ADR;
  assign wr_st = req && we_i && sel_i[0] && adr_i == {STAT_IDX[9:0], 2'h0};
  assign tx_ev = tx_crc_done_i || tx_abort_done_i || tx_flag_done_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack too long");
  ack_time_a: assert property (req |=> ack_o) else $error("ack late");
  rx_full_a: assert property (rx_load_i && ce_i |=> rx_irq_o)
    else $error("rx byte not flagged");
  tx_fill_a: assert property (wr_tx |=> tx_valid_o)
    else $error("tx buffer not full");
  tx_empty_a: assert property (tx_take_i && ce_i && !wr_tx |=> !tx_valid_o)
    else $error("tx buffer not emptied");
  take_irq_a: assert property (tx_take_i && tx_valid_o && !tx_last_o && ce_i |=> tx_irq_o)
    else $error("take gave no irq");
  last_quiet_a: assert property (tx_take_i && tx_last_o && !tx_irq_o && !tx_ev && ce_i
    |=> !tx_irq_o) else $error("last byte irq");
  stat_clear_a: assert property (wr_st && !tx_ev && !tx_take_i |=> !tx_irq_o)
    else $error("status write kept irq");
  end_irq_a: assert property ((tx_crc_done_i || tx_abort_done_i) && ce_i
    |=> tx_irq_o) else $error("end of crc or abort gave no irq");
  cover property (tx_crc_done_i ##1 tx_irq_o);
  cover property (wr_st ##1 !tx_irq_o);
  cover property (rx_load_i ##1 rx_irq_o);
endmodule

// ---- tb/hss_line_model.sv ----
// line-side model: the framer facing the remote station, as event pulses.
// assumes the bench calls one task at a time from a single process.
module hss_line_model (
  // clock
  input  wire logic       clk_i,
  // received byte
  output logic            rx_load_o,
  output logic      [7:0] rx_data_o,
  output logic      [1:0] rx_frame_o,
  output logic            rx_short_o,
  // transmit events: take, crc, abort, flag
  output logic      [3:0] tx_ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet lines at start
  initial
  begin
    rx_load_o = 1'b0;
    rx_data_o = 8'h00;
    rx_frame_o = 2'h0;
    rx_short_o = 1'b0;
    tx_ev_o = 4'h0;
  end
  // one byte; data and frame lines inverted afterwards so stale data never looks valid
  task automatic rx(input logic [7:0] d, input logic [1:0] f, input logic s);
    @(posedge clk_i);
    rx_load_o  <= 1'b1;
    rx_data_o  <= d;
    rx_frame_o <= f;
    rx_short_o <= s;
    @(posedge clk_i);
    rx_load_o  <= 1'b0;
    rx_data_o  <= ~d;
    rx_frame_o <= ~f;
  endtask
  // one-cycle event pulse
  task automatic ev(input int k);
    @(posedge clk_i);
    tx_ev_o <= 4'h1 << k;
    @(posedge clk_i);
    tx_ev_o <= 4'h0;
  endtask
endmodule

// ---- tb/tb_hdlc_serial_status_register.sv ----
// bench for the hdlc status block: wishbone tasks, line model, status model.
// assumes the design acks each request one cycle after taking it.
module tb_hdlc_serial_status_register
  import hss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] SADR = {HSS_STAT_E_IDX[9:0], 2'h0};
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic        cyc_i, stb_i, we_i, ack_o, rx_load_i, rx_short_i;
  logic        tx_last_o, tx_valid_o, rx_irq_o, tx_irq_o, irq_o;
  logic [11:0] adr_i;
  logic [3:0]  sel_i, ev;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0]  rx_data_i, tx_data_o;
  logic [1:0]  rx_frame_i, tx_min_flags_o, frm, cause;
  logic        rxf, ovr, txf, sh;
  logic [15:0] lfsr = 16'h5b81;
  int          fail_count, n_tests, ticks;
  // ****
  // design and line model
  // ****
  hss_status hss_status_i (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .rx_load_i, .rx_data_i, .rx_frame_i,
    .rx_short_i, .tx_take_i(ev[0]), .tx_crc_done_i(ev[1]), .tx_abort_done_i(ev[2]),
    .tx_flag_done_i(ev[3]), .tx_data_o, .tx_last_o, .tx_valid_o, .tx_min_flags_o,
    .rx_irq_o, .tx_irq_o, .irq_o);
  hss_line_model line_i (.clk_i, .rx_load_o(rx_load_i), .rx_data_o(rx_data_i),
    .rx_frame_o(rx_frame_i), .rx_short_o(rx_short_i), .tx_ev_o(ev));
  always #5 clk_i = ~clk_i;
  // hang guard, far above the run length
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      chk(0, 1, "timeout");
      tally_and_finish();
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // status read against the model
  task automatic stat(input string m);
    wb(1'b0, SADR, 32'h0);
    chk(rd, {24'h0, rxf, frm[1], ovr, frm[0], txf, cause, sh}, m);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {15'h0, 32'h0, 4'hf};
    {rxf, ovr, txf, sh, frm, cause} = 8'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    stat("reset");
    chk(tx_min_flags_o, HSS_FLAGS_TWO, "reset flags");
    for (int k = 0; k < 4; k++)
    begin
      lfsr = nx(lfsr);
      line_i.rx(lfsr[7:0], k[1:0], lfsr[8]);
      {rxf, frm, sh} = {1'b1, k[1:0], lfsr[8]};
      stat("rx class");
      chk(rx_irq_o, 1, "rx irq");
      wb(1'b0, HSS_RXDATA_ADR, 32'h0);
      chk(rd, lfsr[7:0], "rx data");
      wb(1'b0, SADR, 32'h0);
      chk({rd[7], rx_irq_o}, 0, "rx empty");
    end
    line_i.rx(8'h11, HSS_FRM_DATA, 1'b0);
    line_i.rx(8'h22, HSS_FRM_CRCOK, 1'b1);
    {rxf, ovr, frm, sh} = 5'h1d;
    stat("overrun");
    wb(1'b0, HSS_RXDATA_ADR, 32'h0);
    chk(rd, 32'h22, "overrun newest byte");
    wb(1'b0, SADR, 32'h0);
    chk({rd[7], rd[5]}, 0, "overrun cleared");
    {rxf, ovr} = 2'h0;
    wb(1'b1, HSS_TXDATA_ADR, 32'h0a5);
    txf = 1'b1;
    chk({tx_valid_o, tx_last_o, tx_data_o}, 10'h2a5, "tx buffer");
    stat("tx full");
    line_i.ev(0);
    txf = 1'b0;
    @(negedge clk_i);
    chk(tx_irq_o, 1, "take irq");
    stat("empty cause");
    wb(1'b1, SADR, {16'h0, lfsr});
    chk(tx_irq_o, 0, "status write");
    stat("value ignored");
    wb(1'b1, HSS_TXDATA_ADR, 32'h15a);
    line_i.ev(0);
    @(negedge clk_i);
    chk({tx_irq_o, tx_valid_o}, 0, "last take");
    for (int k = 1; k < 4; k++)
    begin
      line_i.ev(k);
      cause = k[1:0];
      stat("tx cause");
      chk(tx_irq_o, 1, "end irq");
      wb(1'b1, HSS_TXDATA_ADR, 32'h100 | k);
      chk({tx_irq_o, tx_min_flags_o}, (k == 1) ? 1 : 2, "flags");
      if (k == 1)
      begin
        line_i.ev(3);
        @(negedge clk_i);
        chk(tx_irq_o, 0, "separating flag");
      end
      line_i.ev(0);
    end
    wb(1'b1, HSS_INTSTAT_ADR, 32'h7);
    wb(1'b0, HSS_INTSTAT_ADR, 32'h0);
    chk(rd, 0, "sticky cleared");
    wb(1'b1, HSS_INTMASK_ADR, 32'h1);
    line_i.rx(8'h3c, HSS_FRM_ABORT, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1, "irq raised");
    wb(1'b1, HSS_INTSTAT_ADR, 32'h1);
    @(negedge clk_i);
    chk(irq_o, 0, "irq cleared");
    wb(1'b1, HSS_INTMASK_ADR, 32'h0);
    line_i.rx(8'h5a, HSS_FRM_DATA, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 0, "irq masked");
    sel_i <= 4'he;
    wb(1'b1, HSS_TXDATA_ADR, 32'h0ff);
    sel_i <= 4'hf;
    chk(tx_valid_o, 0, "sel ignored");
    ce_i <= 1'b0;
    line_i.ev(1);
    ce_i <= 1'b1;
    @(negedge clk_i);
    chk(tx_irq_o, 0, "frozen crc end");
    wb(1'b1, 12'h7f0, 32'hff);
    wb(1'b0, 12'h7f0, 32'h0);
    chk(rd, 0, "unmapped");
    tally_and_finish();
  end
endmodule

bind hss_status hss_status_asserts #(.STAT_IDX(STAT_IDX)) hss_status_asserts_i (.clk_i,
  .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .ack_o, .rx_load_i, .tx_take_i,
  .tx_crc_done_i, .tx_abort_done_i, .tx_flag_done_i, .tx_last_o, .tx_valid_o,
  .rx_irq_o, .tx_irq_o);
